/* design/hsr_device.sv */
/*
 * Device end of the slow direct register handshake: four host-visible
 * registers answered with a delayed active-low acknowledge.
 * Assumes the host keeps its strobe low until acknowledge and observes the
 * turnaround gaps; strobes are synchronous to core_clk_in.
 * Each strobe still passes two flops, so a strobe from a slower host clock
 * can be wired in later without a metastability hazard.
 * Acknowledge and read drive stand until the released strobe has passed the
 * same two flops, so the host always sees acknowledge rise after its strobe.
 * Address 3 holds status and is read only; a write there is acknowledged and
 * leaves every register unchanged.
 */
`timescale 1ns/100ps
module hsr_device
   import hsr_pkg::*;
(
   // Clock and reset.
   input  wire logic              core_clk_in,
   input  wire logic              reset_n_in,
   // Link to the host end.
   hsr_link_if.device_mp          link,
   // Statistics readiness and status word.
   input  wire logic              statistics_ready_in,
   input  wire logic [DATA_W-1:0] status_in,
   // Register outputs and indirect data path.
   output logic [DATA_W-1:0]      index_out,
   output logic [DATA_W-1:0]      mask_out,
   output logic [DATA_W-1:0]      indirect_wr_data_out,
   output logic                   indirect_wr_out,
   output logic                   indirect_rd_out,
   input  wire logic [DATA_W-1:0] indirect_rd_data_in
);

   typedef struct packed {
      // Handshake progress.
      hsr_dev_state_type state;
      // Strobe synchronisers, stage 0 then stage 1.
      logic [1:0]        rd_sync;
      logic [1:0]        wr_sync;
      // Access in flight and its timing.
      logic              is_read;
      logic [ADDR_W-1:0] addr;
      logic [CNT_W-1:0]  cnt;
      logic [CNT_W-1:0]  stall_cnt;
      // Link drive.
      logic [DATA_W-1:0] rdata;
      logic              rdata_oe;
      logic              ack;
      // Register contents and indirect pulses.
      logic [DATA_W-1:0] index;
      logic [DATA_W-1:0] mask;
      logic [DATA_W-1:0] ind_wdata;
      logic              ind_wr;
      logic              ind_rd;
   } hsr_dev_regs_type;

   hsr_dev_regs_type regs_r;
   hsr_dev_regs_type regs_nxt;

   // True while either synchronised strobe is low on the pin.
   function automatic logic strobe_seen(input hsr_dev_regs_type r);
      strobe_seen = r.rd_sync[1] || r.wr_sync[1];
   endfunction : strobe_seen

   // True while the stretch counter may still grow; the bound keeps the
   // acknowledge inside the longest stretched wait.
   function automatic logic stall_room(input logic [CNT_W-1:0] c);
      stall_room = (c < CNT_W'(STALL_MAX_CYC - DEV_ACK_CYC - 4));
   endfunction : stall_room

   // Read mux over the four slow registers.
   // Indirect data and status come straight from their inputs.
   function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a,
                                                  input hsr_dev_regs_type r);
      case (a)
         2'h0:    read_mux = r.index;
         2'h1:    read_mux = indirect_rd_data_in;
         2'h2:    read_mux = r.mask;
         default: read_mux = status_in;
      endcase
   endfunction : read_mux

   // Next state: strobes pass two flops, then the access is timed and acknowledged.
   // Read data is driven well before acknowledge, so the host may take it at
   // the acknowledge edge. The one-cycle indirect pulses are cleared every
   // cycle and raised only on the cycle that starts an access or raises acknowledge.
   always_comb
   begin
      regs_nxt = regs_r;
      regs_nxt.rd_sync = {regs_r.rd_sync[0], ~link.rd_strobe_n};
      regs_nxt.wr_sync = {regs_r.wr_sync[0], ~link.wr_strobe_n};
      regs_nxt.ind_wr = 1'b0;
      regs_nxt.ind_rd = 1'b0;
      case (regs_r.state)
         HSR_DEV_IDLE:
         begin
            // A strobe seen in the second stage starts the access.
            if (strobe_seen(regs_r))
            begin
               regs_nxt.state = HSR_DEV_BUSY;
               regs_nxt.is_read = regs_r.rd_sync[1];
               // The address is stable long before the strobe gets here.
               regs_nxt.addr = link.addr;
               regs_nxt.cnt = '0;
               regs_nxt.stall_cnt = '0;
               // Tell the indirect side that its word is being read.
               regs_nxt.ind_rd = regs_r.rd_sync[1] && (link.addr == 2'h1);
            end
         end
         HSR_DEV_BUSY:
         begin
            // While statistics are not ready the access waits, bounded.
            if (!statistics_ready_in && stall_room(regs_r.stall_cnt))
            begin
               regs_nxt.stall_cnt = regs_r.stall_cnt + 1'b1;
            end
            else
            begin
               // Normal progress toward read data and acknowledge.
               regs_nxt.cnt = regs_r.cnt + 1'b1;
            end
            // Read data goes on the bus ahead of acknowledge.
            if (regs_r.is_read && (regs_r.cnt == CNT_W'(DEV_RD_DATA_CYC)))
            begin
               regs_nxt.rdata = read_mux(regs_r.addr, regs_r);
               regs_nxt.rdata_oe = 1'b1;
            end
            if (regs_r.cnt == CNT_W'(DEV_ACK_CYC))
            begin
               regs_nxt.state = HSR_DEV_ACK;
               regs_nxt.ack = 1'b1;
               // Write data is taken from the bus as acknowledge is raised.
               if (!regs_r.is_read)
               begin
                  case (regs_r.addr)
                     2'h0:    regs_nxt.index = link.data_bus;
                     2'h1:
                     begin
                        regs_nxt.ind_wdata = link.data_bus;
                        regs_nxt.ind_wr = 1'b1;
                     end
                     2'h2:    regs_nxt.mask = link.data_bus;
                     // Status is read only; the write is dropped.
                     default: regs_nxt.mask = regs_r.mask;
                  endcase
               end
            end
         end
         HSR_DEV_ACK:
         begin
            // Acknowledge and read drive drop once the strobe is seen released.
            if (!strobe_seen(regs_r))
            begin
               regs_nxt.state = HSR_DEV_IDLE;
               regs_nxt.ack = 1'b0;
               regs_nxt.rdata_oe = 1'b0;
            end
         end
         default:
         begin
            regs_nxt.state = HSR_DEV_IDLE;
         end
      endcase
   end

   // State register.
   // Reset leaves acknowledge high, the read drive off and the strobes seen
   // as released, so no access can start from reset.
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         regs_r <= '{state:     HSR_DEV_IDLE,
                     rdata:     DATA_RST,
                     index:     DATA_RST,
                     mask:      DATA_RST,
                     ind_wdata: DATA_RST,
                     default:   '0};
      end
      else
      begin
         regs_r <= regs_nxt;
      end
   end

   // Link outputs: acknowledge and read drive, all from flops.
   assign link.ack_n = ~regs_r.ack;
   assign link.dev_data = regs_r.rdata;
   assign link.dev_data_oe = regs_r.rdata_oe;

   // Register contents seen by the rest of the device.
   assign index_out = regs_r.index;
   assign mask_out = regs_r.mask;

   // Indirect data path: write data with its pulse, and the read pulse.
   assign indirect_wr_data_out = regs_r.ind_wdata;
   assign indirect_wr_out = regs_r.ind_wr;
   assign indirect_rd_out = regs_r.ind_rd;

endmodule : hsr_device

/* design/hsr_pkg.sv */
/*
 * Package for the slow host register handshake: timing counts, field widths
 * and state types shared by the device end and the host end.
 * Assumes one 200 MHz core clock drives both ends; the video clock period of 7.4
 * core clock cycles is rounded down to 7 where whole cycles are needed.
 */
package hsr_pkg;

   // Core clock period and video clock period in picoseconds.
   localparam int CORE_CLK_PERIOD_PS = 5000;
   localparam int VIDEO_CLK_PERIOD_PS = 37000;
   // Core clock cycles per video clock period, rounded down.
   localparam int VIDEO_CLOCK_CYC = VIDEO_CLK_PERIOD_PS / CORE_CLK_PERIOD_PS;

   // Read data delay limit: 4 video clock periods plus 16 ns.
   localparam int RD_DATA_VIDEO_CLOCK = 4;
   localparam int RD_DATA_EXTRA_PS = 16000;
   localparam int RD_DATA_MAX_CYC =
      (RD_DATA_VIDEO_CLOCK * VIDEO_CLK_PERIOD_PS + RD_DATA_EXTRA_PS) / CORE_CLK_PERIOD_PS;
   // Read acknowledge limit: 7 video clock periods plus 14.8 ns.
   localparam int RD_ACK_VIDEO_CLOCK = 7;
   localparam int RD_ACK_EXTRA_PS = 14800;
   localparam int RD_ACK_MAX_CYC =
      (RD_ACK_VIDEO_CLOCK * VIDEO_CLK_PERIOD_PS + RD_ACK_EXTRA_PS) / CORE_CLK_PERIOD_PS;
   // Write acknowledge limit: 4.3 video clock periods plus 14.8 ns (tenths).
   localparam int WR_ACK_VIDEO_CLOCK_X10 = 43;
   localparam int WR_ACK_EXTRA_PS = 14800;
   localparam int WR_ACK_MAX_CYC =
      (WR_ACK_VIDEO_CLOCK_X10 * VIDEO_CLK_PERIOD_PS / 10 + WR_ACK_EXTRA_PS) / CORE_CLK_PERIOD_PS;
   // Extended wait while statistics are not ready: 52 video clock periods.
   localparam int STALL_VIDEO_CLOCK = 52;
   localparam int STALL_MAX_CYC = STALL_VIDEO_CLOCK * VIDEO_CLK_PERIOD_PS / CORE_CLK_PERIOD_PS;
   // Read-to-write turnaround: 1.5 video clock periods minus 4.1 ns, rounded up.
   localparam int RD_WR_VIDEO_CLOCK_X10 = 15;
   localparam int RD_WR_OFFSET_PS = 4100;
   localparam int RD_WR_MIN_CYC =
      (RD_WR_VIDEO_CLOCK_X10 * VIDEO_CLK_PERIOD_PS / 10 - RD_WR_OFFSET_PS
       + CORE_CLK_PERIOD_PS - 1) / CORE_CLK_PERIOD_PS;
   // Write-to-read turnaround: 0.8 video clock periods plus 7.4 ns, rounded up.
   localparam int WR_RD_VIDEO_CLOCK_X10 = 8;
   localparam int WR_RD_OFFSET_PS = 7400;
   localparam int WR_RD_MIN_CYC =
      (WR_RD_VIDEO_CLOCK_X10 * VIDEO_CLK_PERIOD_PS / 10 + WR_RD_OFFSET_PS
       + CORE_CLK_PERIOD_PS - 1) / CORE_CLK_PERIOD_PS;

   // Device answer latency chosen well inside every limit above.
   localparam int DEV_RD_DATA_CYC = 2 * VIDEO_CLOCK_CYC;
   localparam int DEV_ACK_CYC = 3 * VIDEO_CLOCK_CYC;

   // Bus widths and the counter width used by both ends.
   localparam int ADDR_W = 2;
   localparam int DATA_W = 16;
   localparam int CNT_W = 10;

   // Reset values.
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

   typedef enum logic [1:0] {HSR_DEV_IDLE, HSR_DEV_BUSY, HSR_DEV_ACK} hsr_dev_state_type;
   typedef enum logic [2:0] {HSR_HST_IDLE, HSR_HST_GAP, HSR_HST_STROBE, HSR_HST_RELEASE}
      hsr_hst_state_type;

endpackage : hsr_pkg

/* design/hsr_link_if.sv */
/*
 * Interface joining the host end to the device end of the slow register port.
 * Assumes both ends share core_clk_in; the data bus is two-way and the
 * resolved level is worked out here from the output enables.
 */
`timescale 1ns/100ps
interface hsr_link_if
   import hsr_pkg::*;
();
   logic              rd_strobe_n;   // Read strobe, driven by host.
   logic              wr_strobe_n;   // Write strobe, driven by host.
   logic [ADDR_W-1:0] addr;          // Register select, driven by host.
   logic [DATA_W-1:0] host_data;     // Host drive value for the data bus.
   logic              host_data_oe;  // Host drives data bus while high.
   logic [DATA_W-1:0] dev_data;      // Device drive value for the data bus.
   logic              dev_data_oe;   // Device drives data bus while high.
   logic              ack_n;         // Acknowledge, driven by device.
   logic [DATA_W-1:0] data_bus;      // Resolved data bus level.

   // Resolve the shared data bus; the device drive takes priority over the host.
   assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : DATA_RST);

   modport device_mp (
      input  rd_strobe_n, wr_strobe_n, addr, data_bus,
      output dev_data, dev_data_oe, ack_n
   );
   modport host_mp (
      output rd_strobe_n, wr_strobe_n, addr, host_data, host_data_oe,
      input  data_bus, ack_n
   );
endinterface : hsr_link_if

/* design/hsr_host.sv */
/*
 * Host end of the slow direct register handshake: turns one user request
 * into a strobe that stays low until acknowledge, with turnaround gaps.
 * Assumes the device end shares core_clk_in.
 */
`timescale 1ns/100ps
module hsr_host
   import hsr_pkg::*;
(
   input  wire logic              core_clk_in,
   input  wire logic              reset_n_in,
   hsr_link_if.host_mp            link,
   input  wire logic              req_valid_in,
   input  wire logic              req_write_in,
   input  wire logic [ADDR_W-1:0] req_addr_in,
   input  wire logic [DATA_W-1:0] req_wdata_in,
   output logic                   req_ready_out,
   output logic                   rsp_valid_out,
   output logic [DATA_W-1:0]      rsp_rdata_out
);

   typedef struct packed {
      hsr_hst_state_type state;
      logic              last_read;
      logic              last_write;
      logic              is_write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [CNT_W-1:0]  gap;
      logic              rd_n;
      logic              wr_n;
      logic              data_oe;
      logic              rsp_valid;
      logic [DATA_W-1:0] rdata;
   } hsr_hst_regs_type;

   hsr_hst_regs_type regs_r;
   hsr_hst_regs_type regs_nxt;

   // Gap needed before the next strobe given the previous access.
   function automatic logic [CNT_W-1:0] gap_need(input logic wr, input hsr_hst_regs_type r);
      if (wr && r.last_read)
         gap_need = CNT_W'(RD_WR_MIN_CYC);
      else if (!wr && r.last_write)
         gap_need = CNT_W'(WR_RD_MIN_CYC);
      else
         gap_need = '0;
   endfunction : gap_need

   // Next state of the request sequencer.
   always_comb
   begin
      regs_nxt = regs_r;
      regs_nxt.rsp_valid = 1'b0;
      if (regs_r.gap != '0)
      begin
         regs_nxt.gap = regs_r.gap - 1'b1;
      end
      case (regs_r.state)
         HSR_HST_IDLE:
         begin
            if (req_valid_in)
            begin
               regs_nxt.state = HSR_HST_GAP;
               regs_nxt.is_write = req_write_in;
               regs_nxt.addr = req_addr_in;
               regs_nxt.wdata = req_wdata_in;
               regs_nxt.gap = gap_need(req_write_in, regs_r);
               regs_nxt.data_oe = req_write_in;
            end
         end
         HSR_HST_GAP:
         begin
            if (regs_r.gap == '0)
            begin
               regs_nxt.state = HSR_HST_STROBE;
               regs_nxt.rd_n = regs_r.is_write;
               regs_nxt.wr_n = ~regs_r.is_write;
            end
         end
         HSR_HST_STROBE:
         begin
            // Strobe is held with no timeout until the device answers.
            if (!link.ack_n)
            begin
               regs_nxt.state = HSR_HST_RELEASE;
               regs_nxt.rd_n = 1'b1;
               regs_nxt.wr_n = 1'b1;
               regs_nxt.rdata = regs_r.is_write ? regs_r.rdata : link.data_bus;
               regs_nxt.last_read = ~regs_r.is_write;
               regs_nxt.last_write = regs_r.is_write;
            end
         end
         HSR_HST_RELEASE:
         begin
            // Wait for acknowledge to drop before the next access.
            if (link.ack_n)
            begin
               regs_nxt.state = HSR_HST_IDLE;
               regs_nxt.data_oe = 1'b0;
               regs_nxt.rsp_valid = 1'b1;
            end
         end
         default:
         begin
            regs_nxt.state = HSR_HST_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         regs_r <= '{state: HSR_HST_IDLE, rd_n: 1'b1, wr_n: 1'b1, wdata: DATA_RST,
                     rdata: DATA_RST, default: '0};
      end
      else
      begin
         regs_r <= regs_nxt;
      end
   end

   assign link.rd_strobe_n = regs_r.rd_n;
   assign link.wr_strobe_n = regs_r.wr_n;
   assign link.addr = regs_r.addr;
   assign link.host_data = regs_r.wdata;
   assign link.host_data_oe = regs_r.data_oe;
   assign req_ready_out = (regs_r.state == HSR_HST_IDLE);
   assign rsp_valid_out = regs_r.rsp_valid;
   assign rsp_rdata_out = regs_r.rdata;

endmodule : hsr_host

/* verif/hsr_link_checker.sv */
/* Checker for the slow register link: acknowledge bounds, strobe holding and turnaround gaps.
   Assumes it is instantiated beside the link interface and sees its signals directly. */
`timescale 1ns/100ps
module hsr_link_checker
   import hsr_pkg::*;
(
   input  wire logic core_clk_in,
   input  wire logic reset_n_in,
   input  wire logic statistics_ready_in,
   input  wire logic rd_strobe_n,
   input  wire logic wr_strobe_n,
   input  wire logic host_data_oe,
   input  wire logic dev_data_oe,
   input  wire logic ack_n
);
   localparam int RD_LIM    = RD_ACK_MAX_CYC;
   localparam int WR_LIM    = WR_ACK_MAX_CYC;
   localparam int DATA_LIM  = RD_DATA_MAX_CYC;
   localparam int STALL_LIM = STALL_MAX_CYC + 4;
   logic [CNT_W-1:0] rd_gap_r;
   logic [CNT_W-1:0] wr_gap_r;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);

   // Count cycles since each strobe was last released, saturating.
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rd_gap_r <= '1;
         wr_gap_r <= '1;
      end
      else
      begin
         rd_gap_r <= !rd_strobe_n ? '0 : (&rd_gap_r ? rd_gap_r : rd_gap_r + 1'b1);
         wr_gap_r <= !wr_strobe_n ? '0 : (&wr_gap_r ? wr_gap_r : wr_gap_r + 1'b1);
      end
   end

   rd_data_bound_a : assert property (
      $fell(rd_strobe_n) && statistics_ready_in |-> ##[1:DATA_LIM] dev_data_oe)
      else $error("read data late");
   rd_ack_bound_a : assert property (
      $fell(rd_strobe_n) && statistics_ready_in |-> ##[1:RD_LIM] !ack_n)
      else $error("read acknowledge late");
   wr_ack_bound_a : assert property (
      $fell(wr_strobe_n) && statistics_ready_in |-> ##[1:WR_LIM] !ack_n)
      else $error("write acknowledge late");
   stall_bound_a : assert property (
      $fell(rd_strobe_n && wr_strobe_n) |-> ##[1:STALL_LIM] !ack_n)
      else $error("stalled acknowledge too late");
   ack_hold_a : assert property (
      !ack_n && !(rd_strobe_n && wr_strobe_n) |=> !ack_n)
      else $error("acknowledge dropped while strobe low");
   ack_release_a : assert property (
      (rd_strobe_n && wr_strobe_n) [*5] |-> ack_n)
      else $error("acknowledge not released");
   rd_strobe_hold_a : assert property (
      !rd_strobe_n && ack_n |=> !rd_strobe_n)
      else $error("read strobe released before acknowledge");
   wr_strobe_hold_a : assert property (
      !wr_strobe_n && ack_n |=> !wr_strobe_n && host_data_oe)
      else $error("write strobe or data released before acknowledge");
   rd_wr_gap_a : assert property (
      $fell(wr_strobe_n) |-> rd_gap_r >= CNT_W'(RD_WR_MIN_CYC))
      else $error("read to write gap too short");
   wr_rd_gap_a : assert property (
      $fell(rd_strobe_n) |-> wr_gap_r >= CNT_W'(WR_RD_MIN_CYC))
      else $error("write to read gap too short");
   bus_owner_a : assert property (
      dev_data_oe |-> !host_data_oe && wr_strobe_n)
      else $error("data bus driven by both ends");
endmodule : hsr_link_checker

/* verif/host_slow_register_handshake_tb.sv */
/* Testbench joining host and device ends across the link; scoreboard of expected results.
   Assumes one 200 MHz clock and inputs driven at the falling edge. */
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
   $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module host_slow_register_handshake_tb
   import hsr_pkg::*;
;
   typedef struct {logic wr; logic [ADDR_W-1:0] addr; logic [DATA_W-1:0] data;} hsr_note_type;
   logic              core_clk_in = 0;
   logic              reset_n_in = 0;
   logic              statistics_ready_in = 1;
   logic [DATA_W-1:0] status_in = 16'h0000;
   logic [DATA_W-1:0] ind_rd = 16'h0000;
   logic              req_valid_in = 0;
   logic              req_write_in = 0;
   logic [ADDR_W-1:0] req_addr_in = 0;
   logic [DATA_W-1:0] req_wdata_in = 16'h0000;
   logic              req_ready_out, rsp_valid_out, indirect_wr_out, indirect_rd_out;
   logic [DATA_W-1:0] rsp_rdata_out, index_out, mask_out, ind_wr_data;
   logic [DATA_W-1:0] index_sh = 16'h0000;
   logic [DATA_W-1:0] mask_sh = 16'h0000;
   int                failures = 0, comparisons = 0, cycles = 0, ewp = 0, erp = 0, wp = 0, rp = 0;
   hsr_note_type      notes[$];

   hsr_link_if hsr_link_if_i ();
   hsr_device hsr_device_i (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .link(hsr_link_if_i.device_mp), .statistics_ready_in(statistics_ready_in),
      .status_in(status_in), .index_out(index_out), .mask_out(mask_out),
      .indirect_wr_data_out(ind_wr_data), .indirect_wr_out(indirect_wr_out),
      .indirect_rd_out(indirect_rd_out), .indirect_rd_data_in(ind_rd));
   hsr_host hsr_host_i (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .link(hsr_link_if_i.host_mp), .req_valid_in(req_valid_in), .req_write_in(req_write_in),
      .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
      .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out));
   hsr_link_checker hsr_link_checker_i (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
      .statistics_ready_in(statistics_ready_in), .rd_strobe_n(hsr_link_if_i.rd_strobe_n),
      .wr_strobe_n(hsr_link_if_i.wr_strobe_n), .host_data_oe(hsr_link_if_i.host_data_oe),
      .dev_data_oe(hsr_link_if_i.dev_data_oe), .ack_n(hsr_link_if_i.ack_n));

   // Clock of 5 ns period.
   initial
   begin
      forever #2.5 core_clk_in = ~core_clk_in;
   end

   // Notes the expected result, then hands one request to the host end.
   task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      hsr_note_type n;
      n = '{wr, a, d};
      if (!wr)
         n.data = (a == 2'd0) ? index_sh : (a == 2'd1) ? ind_rd : (a == 2'd2) ? mask_sh : status_in;
      else if (a == 2'd3)
         n = '{1'b1, 2'd2, mask_sh};
      if (wr && a == 2'd0) index_sh = d;
      if (wr && a == 2'd2) mask_sh = d;
      if (a == 2'd1) begin if (wr) ewp++; else erp++; end
      notes.push_back(n);
      @(negedge core_clk_in);
      {req_valid_in, req_write_in, req_addr_in, req_wdata_in} = {1'b1, wr, a, d};
      while (req_ready_out !== 1'b1) @(negedge core_clk_in);
      @(negedge core_clk_in);
      req_valid_in = 0;
   endtask : access

   // Waits until every noted result has been seen.
   task automatic drain(input string name);
      while (notes.size() != 0) @(posedge core_clk_in);
      $display("Test %s done, %0d comparisons so far", name, comparisons);
   endtask : drain

   task automatic print_verdict();
      $display("Comparisons %0d, failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict

   // Takes the oldest note at each finished access and compares.
   always @(posedge core_clk_in)
   begin
      hsr_note_type n;
      cycles++;
      if (indirect_wr_out === 1'b1) wp++;
      if (indirect_rd_out === 1'b1) rp++;
      if (rsp_valid_out === 1'b1)
      begin
         n = notes.pop_front();
         if (!n.wr) `CHK(rsp_rdata_out, n.data)
         else if (n.addr == 2'd0) `CHK(index_out, n.data)
         else if (n.addr == 2'd1) `CHK(ind_wr_data, n.data)
         else `CHK(mask_out, n.data)
      end
      if (cycles == 30000)
      begin
         failures++;
         $display("[FAIL] %0t run did not finish", $time);
         print_verdict();
      end
   end

   // Main sequence: all registers, random mixed traffic, then stalled accesses.
   initial
   begin
      void'($urandom(56));
      repeat (2) @(negedge core_clk_in);
      reset_n_in = 1;
      status_in = 16'($urandom);
      ind_rd = 16'($urandom);
      for (int a = 0; a < 4; a++)
      begin
         access(1'b1, 2'(a), 16'($urandom));
         access(1'b0, 2'(a), 16'h0000);
      end
      drain("registers");
      repeat (40) access(1'($urandom), 2'($urandom), 16'($urandom));
      drain("random");
      @(negedge core_clk_in);
      statistics_ready_in = 0;
      access(1'b1, 2'd2, 16'hA5A5);
      access(1'b0, 2'd2, 16'h0000);
      access(1'b0, 2'd1, 16'h0000);
      drain("stall");
      @(negedge core_clk_in);
      statistics_ready_in = 1;
      repeat (8) @(posedge core_clk_in);
      `CHK(wp, ewp)
      `CHK(rp, erp)
      print_verdict();
   end
endmodule : host_slow_register_handshake_tb
